// file: rtl/aol_pkg.sv
// shared constants and types for the converter output latch
package aol_pkg;
  localparam int AOL_DATA_W = 8;
  localparam logic [7:0] AOL_DATA_RST = 8'h00;
  localparam logic [7:0] AOL_DATA_ONES = 8'hFF;
  localparam logic [7:0] AOL_DATA_ZERO = 8'h00;
  localparam logic AOL_FLAG_RST = 1'b0;
  localparam logic AOL_MODE_RTZ = 1'b1; // mode pin level selecting return-to-zero coding
  localparam int AOL_MSB_POS = 7;
  localparam int AOL_LSB_POS = 0;
  typedef enum logic [1:0] {
    AOL_ST_IDLE = 2'b00,
    AOL_ST_RUN = 2'b01
  } aol_state_t;
endpackage

// file: rtl/aol_sync.sv
// two flip-flop synchroniser with rising edge detect for the sample strobe
`timescale 1ns/1ps
module aol_sync (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } aol_sync_st_t;
  aol_sync_st_t st_q, st_d;

  // shift chain; only s2 and s3 are looked at
  always_comb begin
    st_d = st_q;
    st_d.s1 = i_async;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.s2;
  assign o_rise = st_q.s2 && !st_q.s3;
endmodule

// file: rtl/aol_top.sv
// converter output latch with overrange coding
`timescale 1ns/1ps
module aol_top
  import aol_pkg::*;
#(
  parameter int DATA_W = AOL_DATA_W
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_sample_strobe,
  input wire logic [DATA_W-1:0] i_conv_word,
  input wire logic i_overrange,
  input wire logic i_overrange_mode_select,
  output logic [DATA_W-1:0] o_data,
  output logic o_overrange_flag,
  output logic o_word_valid
);
  // refuse widths that the eight bit coding constants cannot serve
  if (DATA_W != AOL_DATA_W) begin : g_width_check
    $error("aol_top supports only an eight bit word");
  end

  // pipeline walk for one strobe pulse, in clocks after the pin edge:
  //   the first two clocks carry the strobe through the synchroniser,
  //   the next clock sees the rise, takes the coded sample into the pipeline
  //   and moves the previous sample to the outputs with a one clock valid pulse.
  // word and control pins must be settled a few clocks before the strobe rises,
  // and the strobe must stay high and low for more than one clock, or an edge can be lost.

  // all registered state; the s1 and s2 fields are the pin synchronisers
  typedef struct packed {
    logic [DATA_W-1:0] cw_s1; // word, first stage
    logic [DATA_W-1:0] cw_s2; // word, second stage
    logic [1:0] ctl_s1; // overrange and mode, first stage
    logic ovr_s2; // overrange, second stage
    logic mode_s2; // mode select, second stage
    logic [DATA_W-1:0] pipe_data; // sample taken at the latest rise
    logic pipe_flag; // flag of that sample
    logic [DATA_W-1:0] out_data; // word shown on the pins
    logic out_flag; // flag shown on the pins
    logic out_valid; // one clock pulse after an output load
    aol_state_t state; // idle until the pipeline holds a real sample
  } aol_st_t;

  aol_st_t st_q, st_d;
  logic strobe_rise; // one clock pulse per synchronised strobe rise

  // strobe synchroniser and edge detect; the rise pulse is the only event that
  // moves the pipeline, so a falling strobe or a held-high strobe does nothing,
  // and the detector starts from the idle low level after reset, giving no false rise
  aol_sync u_strobe_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_sample_strobe),
    .o_level(),
    .o_rise(strobe_rise)
  );

  // coding of one sample into flag and data:
  // overrange wins over the word; the mode pin only picks which overrange code is sent,
  // so an in-range sample never depends on the mode
  function automatic logic [DATA_W:0] aol_code(input logic [DATA_W-1:0] word, input logic ovr,
                                               input logic mode);
    logic [DATA_W:0] res;
    res = {1'b0, word};
    case ({ovr, mode == AOL_MODE_RTZ})
      2'h3: begin
        res = {1'b1, AOL_DATA_ZERO}; // return-to-zero code
      end
      2'h2: begin
        res = {1'b0, AOL_DATA_ONES}; // all ones, flag held low
      end
      default: begin
        res = {1'b0, word}; // in range passes word, flag low
      end
    endcase
    return res;
  endfunction

  // next state: synchronisers shift every clock; pipeline and outputs move only on a strobe rise
  always_comb begin
    logic [DATA_W:0] coded;
    coded = '0;
    st_d = st_q;
    // two stages on every pin input; only the second stage is read by logic
    st_d.cw_s1 = i_conv_word;
    st_d.cw_s2 = st_q.cw_s1;
    st_d.ctl_s1 = {i_overrange, i_overrange_mode_select};
    st_d.ovr_s2 = st_q.ctl_s1[1];
    st_d.mode_s2 = st_q.ctl_s1[0];
    // word bits may skew through the stages, but they are settled well before the
    // strobe rise reaches the detector, which is what qualifies the whole word
    coded = aol_code(st_q.cw_s2, st_q.ovr_s2, st_q.mode_s2);
    st_d.out_valid = 1'b0;
    case (st_q.state)
      AOL_ST_IDLE: begin
        // first rise after reset only fills the pipeline; outputs keep the zero word
        if (strobe_rise) begin
          st_d.pipe_data = coded[DATA_W-1:0];
          st_d.pipe_flag = coded[DATA_W];
          st_d.state = AOL_ST_RUN;
        end
      end
      AOL_ST_RUN: begin
        // later rises: previous sample to the outputs, new sample into the pipeline
        if (strobe_rise) begin
          st_d.pipe_data = coded[DATA_W-1:0];
          st_d.pipe_flag = coded[DATA_W];
          st_d.out_data = st_q.pipe_data;
          st_d.out_flag = st_q.pipe_flag;
          st_d.out_valid = 1'b1;
        end
      end
      default: begin
        // unused code: fall back to idle so the next rise refills the pipeline
        st_d.state = AOL_ST_IDLE;
      end
    endcase
  end

  // asynchronous clear puts every stage, the pipeline and the outputs to zero
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs come straight from the state flip-flops, so the capturing logic
  // never sees a glitch between the flag and the data bits
  assign o_data = st_q.out_data;
  assign o_overrange_flag = st_q.out_flag;
  assign o_word_valid = st_q.out_valid;

  // outputs move only right after a strobe edge
  out_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !$past(strobe_rise) |-> $stable({o_overrange_flag, o_data}))
    else $error("outputs changed without a strobe edge");

  // flag high implies zero data
  flag_data_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_overrange_flag |-> o_data == AOL_DATA_ZERO)
    else $error("flag high with nonzero data");

  // one strobe of latency: a loaded output is the sample taken at the prior rise,
  // never the sample taken at the rise that loads it
  latency_one_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    strobe_rise && st_q.state == AOL_ST_RUN |=> o_word_valid
      && {o_overrange_flag, o_data} == $past({st_q.pipe_flag, st_q.pipe_data}))
    else $error("latency check failed");

  // overrange in inhibited mode codes to ones
  nrz_code_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    strobe_rise && st_q.ovr_s2 && st_q.mode_s2 != AOL_MODE_RTZ |=> st_q.pipe_data == AOL_DATA_ONES && !st_q.pipe_flag)
    else $error("inhibited overrange coding wrong");

  // flag never high in inhibited mode
  flag_inhibit_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    strobe_rise && st_q.mode_s2 != AOL_MODE_RTZ |=> !st_q.pipe_flag)
    else $error("flag set in inhibited mode");

  // in range word passes unchanged
  in_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    strobe_rise && !st_q.ovr_s2 |=> st_q.pipe_data == $past(st_q.cw_s2) && !st_q.pipe_flag)
    else $error("in range word altered");

  // output word pairs with the pipeline word of the prior edge
  word_pair_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    strobe_rise |=> {o_overrange_flag, o_data} == $past({st_q.pipe_flag, st_q.pipe_data}))
    else $error("flag and data not moved together");

  // bit order: msb and lsb positions kept
  bit_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    strobe_rise |=> o_data[AOL_MSB_POS] == $past(st_q.pipe_data[AOL_MSB_POS])
      && o_data[AOL_LSB_POS] == $past(st_q.pipe_data[AOL_LSB_POS]))
    else $error("bit order wrong");

  // before the first real word the outputs show the zero word with no valid
  idle_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    st_q.state == AOL_ST_IDLE |-> {o_word_valid, o_overrange_flag, o_data} == '0)
    else $error("outputs not quiet before the first word");

  // the first rise after reset fills the pipeline but loads no real word
  first_edge_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    strobe_rise && st_q.state == AOL_ST_IDLE |=> !o_word_valid && st_q.state == AOL_ST_RUN)
    else $error("first strobe rise produced a word");

  // a valid pulse follows a detected strobe rise only
  valid_cause_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_word_valid |-> $past(strobe_rise))
    else $error("word valid without a strobe rise");

  // valid lasts exactly one clock
  valid_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_word_valid |=> !o_word_valid)
    else $error("word valid longer than one clock");

  // overrange in enabled mode codes to flag high and zero data
  rtz_code_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    strobe_rise && st_q.ovr_s2 && st_q.mode_s2 == AOL_MODE_RTZ |=> st_q.pipe_flag
      && st_q.pipe_data == AOL_DATA_ZERO)
    else $error("enabled overrange coding wrong");

  // a flagged sample in the pipeline always carries zero data
  pipe_pair_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    strobe_rise |=> !st_q.pipe_flag || st_q.pipe_data == AOL_DATA_ZERO)
    else $error("pipeline flag and data disagree");

  // the pipeline keeps its sample between strobe rises
  pipe_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !strobe_rise |=> $stable({st_q.pipe_flag, st_q.pipe_data}))
    else $error("pipeline sample changed without a strobe rise");
endmodule

// file: tb/aol_sink.sv
// downstream capture model for the converter output latch
`timescale 1ns/1ps
module aol_sink (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_data,
  input wire logic i_flag,
  input wire logic i_valid,
  output logic [8:0] o_cap_word,
  output logic o_cap_stb
);
  // take flag and data together on each valid pulse
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cap_word <= 9'h000;
      o_cap_stb <= 1'b0;
    end else begin
      o_cap_stb <= i_valid;
      if (i_valid) begin
        o_cap_word <= {i_flag, i_data};
      end
    end
  end
endmodule

// file: tb/aol_top_tb.sv
// self-checking bench for the converter output latch
`timescale 1ns/1ps
module aol_top_tb;
  import aol_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic strobe = 1'b0;
  logic [7:0] word = 8'h00;
  logic ovr = 1'b0;
  logic mode = 1'b0;
  logic [7:0] data;
  logic flag, valid, cap_stb;
  logic [8:0] cap_word, prev, exp_w;
  logic [8:0] exp_q[$];
  logic have_prev = 1'b0;
  int err_total = 0;
  int checks = 0;
  int seed = 26998;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  aol_top #(.DATA_W(AOL_DATA_W)) dut_u (.i_sys_clk(clk), .i_reset_n(reset_n), .i_sample_strobe(strobe),
    .i_conv_word(word), .i_overrange(ovr), .i_overrange_mode_select(mode), .o_data(data),
    .o_overrange_flag(flag), .o_word_valid(valid));
  aol_sink sink_u (.i_sys_clk(clk), .i_reset_n(reset_n), .i_data(data), .i_flag(flag), .i_valid(valid),
    .o_cap_word(cap_word), .o_cap_stb(cap_stb));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // expected nine-bit output word for one sample
  function automatic logic [8:0] coded(input logic [7:0] w, input logic o, input logic m);
    if (!o) return {1'b0, w};
    return (m == AOL_MODE_RTZ) ? {1'b1, AOL_DATA_ZERO} : {1'b0, AOL_DATA_ONES};
  endfunction
  // hold reset, check quiet outputs, release
  task automatic do_reset();
    @(posedge clk) reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    checks++;
    if ({valid, flag, data} !== 10'h000) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, {valid, flag, data}, 10'h000);
    end
    reset_n <= 1'b1;
    have_prev = 1'b0;
  endtask
  // present one sample, raise and drop the strobe
  task automatic sample(input logic [7:0] w, input logic o, input logic m);
    @(posedge clk);
    word <= w;
    ovr <= o;
    mode <= m;
    repeat (4) @(posedge clk);
    strobe <= 1'b1;
    if (have_prev) exp_q.push_back(prev);
    prev = coded(w, o, m);
    have_prev = 1'b1;
    repeat (3) @(posedge clk);
    strobe <= 1'b0; // a falling edge must not add a word
    repeat (3) @(posedge clk);
  endtask
  // compare each captured word against the oldest note
  always @(posedge clk) begin
    if (cap_stb === 1'b1) begin
      checks++;
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1XX;
      if (cap_word !== exp_w) begin
        err_total++;
        $display("MISMATCH t=%0t got %h exp %h", $time, cap_word, exp_w);
      end
    end
  end
  // main sequence: both modes, boundary words, then random traffic
  initial begin
    for (int m = 0; m < 2; m++) begin
      do_reset();
      sample(8'h00, 1'b0, m[0]);
      sample(8'hFF, 1'b0, m[0]);
      sample(8'h80, 1'b0, m[0]);
      sample(8'h01, 1'b0, m[0]);
      sample(8'h5A, 1'b1, m[0]);
      sample(8'hA5, 1'b1, m[0]);
      sample(8'h3C, 1'b0, m[0]);
      repeat (14) sample(8'($random(seed)), 1'($random(seed)), m[0]);
    end
    checks++;
    if (exp_q.size() != 0) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, exp_q.size(), 0);
    end
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule
